// >>> rtl/dacq_regs.v
// Host register block of a plug-in data-acquisition card: conversion
// trigger, per-channel gain memory, scan multiplexer, digital I/O and
// the 12-bit analog output value.
// Assumes the host port strobes and the converter handshake run on
// core_clk; digital inputs, external trigger and pacer tick are pins.
//
// Operation
// RQ1: Software-selected source: any write to offset 0 starts one conversion.
// RQ2: Control offset 9 bits 1:0 pick software, pacer or external trigger.
// RQ3: Each channel keeps its own 2-bit gain code applied to its conversion.
// RQ4: Write to offset 1 stores bits 1:0 as gain of start channel.
// RQ5: Gain codes 00/01/10/11 select full, half, quarter, eighth scale.
// RQ6: Offset 2 holds stop in 7:4, start in 3:0; readable.
// RQ7: Writing the scan register loads the current channel with start.
// RQ8: Every trigger from any source advances the current channel; a trigger in the same cycle as a scan write loads the start channel instead.
// RQ9: Advance from the stop channel returns to the start channel.
// RQ10: Start field also addresses the gain memory entry written.
// RQ11: Host rewrites scan start and stop after gain updates.
// RQ12: Offsets 3 and 11 read digital inputs 7:0 and 15:8.
// RQ13: Writes to offsets 3 and 11 latch digital outputs, held.
// RQ14: Offsets 4 bits 7:4 and 5 give analog value bits 3:0, 11:4.
// RQ15: Offset 0 reads result 3:0 and channel; offset 1 result 11:4.
// RQ16: Status top bit is 1 while converting, 0 when idle.
// RQ17: Analog output updates when the high byte is written.
// RQ18: Reset clears digital outputs, analog value, scan start and stop.
`timescale 1ns/100ps
`include "dacq_consts.vh"

module dacq_regs #(
    parameter NUM_CHAN = 16
) (
    // Clock and reset
    input  wire        core_clk,
    input  wire        sys_rst,
    // Host byte port
    input  wire [3:0]  ioAddr,
    input  wire        ioWrStb,
    input  wire        ioRdStb,
    input  wire [7:0]  ioWrData,
    output wire [7:0]  ioRdData,
    // Trigger pins
    input  wire        extTrigIn,
    input  wire        pacerTickIn,
    // Converter handshake
    output wire        convStart,
    output wire [3:0]  convChannel,
    output wire [1:0]  convGain,
    input  wire        convDone,
    input  wire [11:0] convResult,
    // Digital I/O pins
    input  wire [15:0] digitalInputs,
    output wire [15:0] digitalOutputs,
    // Analog output
    output wire [11:0] analogOutputValue
);

    ////////////////////////////////////////////////////////////////////
    // Registers

    reg  [7:0]  ioRdData_ff;
    reg  [3:0]  scanStartChannel_ff;
    reg  [3:0]  scanStopChannel_ff;
    reg  [3:0]  muxChannel_ff;
    reg  [1:0]  trigSource_ff;
    reg  [15:0] digitalOutputs_ff;
    reg  [3:0]  dacLowNibble_ff;
    reg  [11:0] analogOutputValue_ff;
    reg         convStart_ff;
    reg  [3:0]  convChannel_ff;
    reg  [1:0]  convGain_ff;
    reg         busy_ff;
    reg  [11:0] conversionResult_ff;
    reg  [3:0]  resultChannelNumber_ff;
    reg  [15:0] diMeta_ff;
    reg  [15:0] diSync_ff;
    reg  [1:0]  extMeta_ff;
    reg  [1:0]  extSync_ff;
    reg  [1:0]  extPrev_ff;
    reg  [1:0]  gainMem_ff [0:NUM_CHAN-1];

    reg  [7:0]  nxt_ioRdData;
    reg  [3:0]  nxt_muxChannel;

    wire        wrTrig;
    wire        wrGain;
    wire        wrScan;
    wire        wrDioLow;
    wire        wrDioHigh;
    wire        wrDacLow;
    wire        wrDacHigh;
    wire        wrControl;
    wire        swSelected;
    wire        extEdge;
    wire        pacerEdge;
    wire        trigger;
    wire        conversionBusy;

    ////////////////////////////////////////////////////////////////////
    // Write decode

    assign wrTrig    = ioWrStb && (ioAddr == `DACQ_OFS_TRIG_LOW);
    assign wrGain    = ioWrStb && (ioAddr == `DACQ_OFS_GAIN_HIGH);
    assign wrScan    = ioWrStb && (ioAddr == `DACQ_OFS_SCAN);
    assign wrDioLow  = ioWrStb && (ioAddr == `DACQ_OFS_DIO_LOW);
    assign wrDioHigh = ioWrStb && (ioAddr == `DACQ_OFS_DIO_HIGH);
    assign wrDacLow  = ioWrStb && (ioAddr == `DACQ_OFS_DAC_LOW);
    assign wrDacHigh = ioWrStb && (ioAddr == `DACQ_OFS_DAC_HIGH);
    assign wrControl = ioWrStb && (ioAddr == `DACQ_OFS_CONTROL);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    always @(posedge core_clk) begin
        if (sys_rst) begin
            diMeta_ff  <= `DACQ_RST_DO;
            diSync_ff  <= `DACQ_RST_DO;
            extMeta_ff <= 2'h0;
            extSync_ff <= 2'h0;
            extPrev_ff <= 2'h0;
        end else begin
            diMeta_ff  <= digitalInputs;
            diSync_ff  <= diMeta_ff;
            extMeta_ff <= {pacerTickIn, extTrigIn};
            extSync_ff <= extMeta_ff;
            extPrev_ff <= extSync_ff;
        end
    end

    // Rising edges seen on the synchronised trigger pins
    assign extEdge   = extSync_ff[0] && !extPrev_ff[0];
    assign pacerEdge = extSync_ff[1] && !extPrev_ff[1];

    ////////////////////////////////////////////////////////////////////
    // Trigger source selection

    // RQ2 source select
    always @(posedge core_clk) begin
        if (sys_rst) begin
            trigSource_ff <= `DACQ_TRIG_SW0;
        end else if (wrControl) begin
            trigSource_ff <= ioWrData[1:0];
        end
    end

    assign swSelected = (trigSource_ff == `DACQ_TRIG_SW0) ||
                        (trigSource_ff == `DACQ_TRIG_SW1);

    // RQ1 software write trigger
    // RQ2 pin triggers gated by source
    assign trigger = (swSelected && wrTrig) ||
                     ((trigSource_ff == `DACQ_TRIG_EXT) && extEdge) ||
                     ((trigSource_ff == `DACQ_TRIG_PACER) && pacerEdge);

    ////////////////////////////////////////////////////////////////////
    // Scan register and multiplexer

    // RQ6 scan register fields
    // RQ18 scan fields cleared
    always @(posedge core_clk) begin
        if (sys_rst) begin
            scanStartChannel_ff <= `DACQ_RST_NIB;
            scanStopChannel_ff  <= `DACQ_RST_NIB;
        end else if (wrScan) begin
            scanStartChannel_ff <=
                ioWrData[`DACQ_SCAN_START_MSB:`DACQ_SCAN_START_LSB];
            scanStopChannel_ff  <=
                ioWrData[`DACQ_SCAN_STOP_MSB:`DACQ_SCAN_STOP_LSB];
        end
    end

    always @* begin
        nxt_muxChannel = muxChannel_ff;
        if (wrScan) begin
            // RQ7 load start channel
            nxt_muxChannel =
                ioWrData[`DACQ_SCAN_START_MSB:`DACQ_SCAN_START_LSB];
        end else if (trigger) begin
            // RQ9 wrap at stop
            if (muxChannel_ff == scanStopChannel_ff) begin
                nxt_muxChannel = scanStartChannel_ff;
            end else begin
                // RQ8 advance per trigger
                nxt_muxChannel = muxChannel_ff + 4'h1;
            end
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            muxChannel_ff <= `DACQ_RST_NIB;
        end else begin
            muxChannel_ff <= nxt_muxChannel;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Gain code memory, one entry per channel

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi = gi + 1) begin : gGain
            localparam integer CHAN_NUM = gi;
            // RQ3 per-channel gain storage
            always @(posedge core_clk) begin
                if (sys_rst) begin
                    // RQ5 full scale by default
                    gainMem_ff[gi] <= `DACQ_GAIN_FULL;
                end else if (wrGain &&
                             (scanStartChannel_ff == CHAN_NUM[3:0])) begin
                    // RQ4 store low two bits
                    // RQ10 start field addresses
                    gainMem_ff[gi] <=
                        ioWrData[`DACQ_GAIN_MSB:`DACQ_GAIN_LSB];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Conversion launch and result capture

    assign conversionBusy = busy_ff;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            convStart_ff           <= 1'b0;
            convChannel_ff         <= `DACQ_RST_NIB;
            convGain_ff            <= `DACQ_GAIN_FULL;
            busy_ff                <= 1'b0;
            conversionResult_ff    <= `DACQ_RST_RES;
            resultChannelNumber_ff <= `DACQ_RST_NIB;
        end else begin
            convStart_ff <= trigger;
            if (trigger) begin
                // RQ3 apply channel gain
                convChannel_ff <= muxChannel_ff;
                convGain_ff    <= gainMem_ff[muxChannel_ff];
            end
            // RQ16 busy flag
            if (trigger) begin
                busy_ff <= 1'b1;
            end else if (convDone) begin
                busy_ff <= 1'b0;
            end
            if (convDone) begin
                conversionResult_ff    <= convResult;
                resultChannelNumber_ff <= convChannel_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Digital outputs and analog output value

    always @(posedge core_clk) begin
        if (sys_rst) begin
            // RQ18 outputs cleared
            digitalOutputs_ff    <= `DACQ_RST_DO;
            dacLowNibble_ff      <= `DACQ_RST_NIB;
            analogOutputValue_ff <= `DACQ_RST_DAC;
        end else begin
            // RQ13 latch output bytes
            if (wrDioLow) begin
                digitalOutputs_ff[7:0] <= ioWrData;
            end
            if (wrDioHigh) begin
                digitalOutputs_ff[15:8] <= ioWrData;
            end
            // RQ14 low nibble staging
            if (wrDacLow) begin
                dacLowNibble_ff <=
                    ioWrData[`DACQ_DAC_LOW_MSB:`DACQ_DAC_LOW_LSB];
            end
            // RQ17 update on high byte
            if (wrDacHigh) begin
                analogOutputValue_ff <= {ioWrData, dacLowNibble_ff};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path

    always @* begin
        nxt_ioRdData = `DACQ_RST_BYTE;
        case (ioAddr)
            `DACQ_OFS_TRIG_LOW: begin
                // RQ15 low result and channel
                nxt_ioRdData = {conversionResult_ff[3:0],
                                resultChannelNumber_ff};
            end
            `DACQ_OFS_GAIN_HIGH: begin
                // RQ15 high result byte
                nxt_ioRdData = conversionResult_ff[11:4];
            end
            `DACQ_OFS_SCAN: begin
                // RQ6 scan readback
                nxt_ioRdData = {scanStopChannel_ff, scanStartChannel_ff};
            end
            `DACQ_OFS_DIO_LOW: begin
                // RQ12 inputs low byte
                nxt_ioRdData = diSync_ff[7:0];
            end
            `DACQ_OFS_DIO_HIGH: begin
                // RQ12 inputs high byte
                nxt_ioRdData = diSync_ff[15:8];
            end
            `DACQ_OFS_STATUS: begin
                // RQ16 busy in top bit
                nxt_ioRdData[`DACQ_STAT_BUSY_BIT] = conversionBusy;
            end
            `DACQ_OFS_CONTROL: begin
                nxt_ioRdData = {6'h00, trigSource_ff};
            end
            default: begin
                nxt_ioRdData = `DACQ_RST_BYTE;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            ioRdData_ff <= `DACQ_RST_BYTE;
        end else if (ioRdStb) begin
            ioRdData_ff <= nxt_ioRdData;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign ioRdData          = ioRdData_ff;
    assign convStart         = convStart_ff;
    assign convChannel       = convChannel_ff;
    assign convGain          = convGain_ff;
    assign digitalOutputs    = digitalOutputs_ff;
    assign analogOutputValue = analogOutputValue_ff;

endmodule

// >>> rtl/dacq_consts.vh
// Offsets, field positions, reset values and codes for the DAQ card
// register block. Included by rtl/dacq_regs.v only.
`ifndef DACQ_CONSTS_VH
`define DACQ_CONSTS_VH

// Port offsets within the 16-byte I/O window
`define DACQ_OFS_TRIG_LOW    4'h0
`define DACQ_OFS_GAIN_HIGH   4'h1
`define DACQ_OFS_SCAN        4'h2
`define DACQ_OFS_DIO_LOW     4'h3
`define DACQ_OFS_DAC_LOW     4'h4
`define DACQ_OFS_DAC_HIGH    4'h5
`define DACQ_OFS_STATUS      4'h8
`define DACQ_OFS_CONTROL     4'h9
`define DACQ_OFS_DIO_HIGH    4'hb

// Scan register fields
`define DACQ_SCAN_STOP_MSB   7
`define DACQ_SCAN_STOP_LSB   4
`define DACQ_SCAN_START_MSB  3
`define DACQ_SCAN_START_LSB  0

// Gain code field and encoding (fraction of jumper full scale)
`define DACQ_GAIN_MSB        1
`define DACQ_GAIN_LSB        0
`define DACQ_GAIN_FULL       2'h0
`define DACQ_GAIN_HALF       2'h1
`define DACQ_GAIN_QUARTER    2'h2
`define DACQ_GAIN_EIGHTH     2'h3

// Analog output low byte carries value bits 3:0 in its bits 7:4
`define DACQ_DAC_LOW_MSB     7
`define DACQ_DAC_LOW_LSB     4

// Control register trigger source codes (bits 1:0)
`define DACQ_TRIG_SW0        2'h0
`define DACQ_TRIG_SW1        2'h1
`define DACQ_TRIG_EXT        2'h2
`define DACQ_TRIG_PACER      2'h3

// Status register busy flag position
`define DACQ_STAT_BUSY_BIT   7

// Reset values
`define DACQ_RST_BYTE        8'h00
`define DACQ_RST_DO          16'h0000
`define DACQ_RST_DAC         12'h000
`define DACQ_RST_NIB         4'h0
`define DACQ_RST_RES         12'h000

`endif

// >>> testbench/dacq_regs_asserts.sv
// Checker for the host register block of the acquisition card.
// Sees only dacq_regs ports; bound into every dacq_regs instance.
`timescale 1ns/100ps
module dacq_regs_asserts (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        sys_rst,
    // Host byte port
    input wire logic [3:0]  ioAddr,
    input wire logic        ioWrStb,
    input wire logic        ioRdStb,
    input wire logic [7:0]  ioWrData,
    input wire logic [7:0]  ioRdData,
    // Converter side and output pins
    input wire logic        convStart,
    input wire logic [3:0]  convChannel,
    input wire logic [1:0]  convGain,
    input wire logic [15:0] digitalOutputs,
    input wire logic [11:0] analogOutputValue
);
    logic [1:0] srcSel_ff;
    logic [7:0] scan_ff;
    logic [3:0] nib_ff;
    logic [3:0] expCh_ff;
    logic [1:0] gain_ff [0:15];
    // Shadow of the host-visible state and the expected mux position
    always @(posedge core_clk) begin
        if (sys_rst) begin
            srcSel_ff <= 2'h0;
            scan_ff <= 8'h00;
            nib_ff <= 4'h0;
            expCh_ff <= 4'h0;
            for (int i = 0; i < 16; i++) gain_ff[i] <= 2'h0;
        end else begin
            if (ioWrStb && ioAddr == 4'h9) srcSel_ff <= ioWrData[1:0];
            if (ioWrStb && ioAddr == 4'h2) scan_ff <= ioWrData;
            if (ioWrStb && ioAddr == 4'h4) nib_ff <= ioWrData[7:4];
            if (ioWrStb && ioAddr == 4'h1)
                gain_ff[scan_ff[3:0]] <= ioWrData[1:0];
            if (ioWrStb && ioAddr == 4'h2) expCh_ff <= ioWrData[3:0];
            else if (convStart)
                expCh_ff <= (convChannel == scan_ff[7:4]) ? scan_ff[3:0]
                                                          : convChannel + 4'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_sw_trigger:
    assert property (ioWrStb && ioAddr == 4'h0 && !srcSel_ff[1] |=> convStart)
        else $error("no conversion start after trigger write");
    a_gain_apply:
    assert property (convStart |-> convGain == gain_ff[convChannel])
        else $error("conversion gain differs from stored code");
    a_scan_mux:
    assert property (convStart |-> convChannel == expCh_ff)
        else $error("conversion channel out of scan order");
    a_scan_read:
    assert property (ioRdStb && ioAddr == 4'h2 |=> ioRdData == scan_ff)
        else $error("scan register read wrong");
    a_dout_low:
    assert property (ioWrStb && ioAddr == 4'h3
                     |=> digitalOutputs[7:0] == $past(ioWrData))
        else $error("low output byte not latched");
    a_dout_high:
    assert property (ioWrStb && ioAddr == 4'hb
                     |=> digitalOutputs[15:8] == $past(ioWrData))
        else $error("high output byte not latched");
    a_dout_hold:
    assert property (!(ioWrStb && (ioAddr == 4'h3 || ioAddr == 4'hb))
                     |=> $stable(digitalOutputs))
        else $error("outputs changed without a write");
    a_dac_update:
    assert property (ioWrStb && ioAddr == 4'h5 |=> analogOutputValue
                     == {$past(ioWrData), $past(nib_ff)})
        else $error("analog value not assembled from bytes");
    a_dac_hold:
    assert property (!(ioWrStb && ioAddr == 4'h5)
                     |=> $stable(analogOutputValue))
        else $error("analog value changed without high byte");
endmodule
bind dacq_regs dacq_regs_asserts u_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .ioAddr(ioAddr),
    .ioWrStb(ioWrStb), .ioRdStb(ioRdStb), .ioWrData(ioWrData),
    .ioRdData(ioRdData), .convStart(convStart),
    .convChannel(convChannel), .convGain(convGain),
    .digitalOutputs(digitalOutputs),
    .analogOutputValue(analogOutputValue)
);

// >>> testbench/dacq_conv_model.sv
// Converter model: answers each start with a done pulse and a result.
// Assumes a one-cycle start pulse on core_clk; slow picks the latency.
`timescale 1ns/100ps
module dacq_conv_model (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Converter handshake
    input  wire logic        convStart,
    input  wire logic [3:0]  convChannel,
    input  wire logic [1:0]  convGain,
    input  wire logic        slow,
    output logic             convDone,
    output logic [11:0]      convResult
);
    logic [3:0]  cnt_ff;
    logic [11:0] res_ff;
    always @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_ff <= 4'h0;
            convDone <= 1'b0;
            res_ff <= 12'h000;
        end else begin
            convDone <= (cnt_ff == 4'h1);
            if (convStart) begin
                cnt_ff <= slow ? 4'h9 : 4'h2;
                res_ff <= {convChannel, 4'h9, 2'h1, convGain};
            end else if (cnt_ff != 4'h0) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
    // Outside the done pulse the result bus carries nothing valid
    assign convResult = convDone ? res_ff : ~res_ff;
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for dacq_regs: host port tasks, queued checks.
// Assumes the converter model finishes within fourteen cycles.
`timescale 1ns/100ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
    errTotal++; $display("mismatch %s exp %h got %h", n, e, a); end end
module tb_top;
    logic        core_clk, sys_rst, ioWrStb, ioRdStb, extTrigIn;
    logic        pacerTickIn, convStart, convDone, slow, rdPend;
    logic [3:0]  ioAddr, convChannel, st, sp, mux;
    logic [7:0]  ioWrData, ioRdData, rq[$];
    logic [1:0]  convGain, gMem [0:15];
    logic [5:0]  chQ[$];
    logic [11:0] convResult, analogOutputValue;
    logic [15:0] digitalInputs, digitalOutputs;
    logic [31:0] rnd;
    int          errTotal, compares;
    dacq_regs #(.NUM_CHAN(16)) uut (.core_clk(core_clk), .sys_rst(sys_rst),
        .ioAddr(ioAddr), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb),
        .ioWrData(ioWrData), .ioRdData(ioRdData), .extTrigIn(extTrigIn),
        .pacerTickIn(pacerTickIn), .convStart(convStart),
        .convChannel(convChannel), .convGain(convGain), .convDone(convDone),
        .convResult(convResult), .digitalInputs(digitalInputs),
        .digitalOutputs(digitalOutputs),
        .analogOutputValue(analogOutputValue));
    dacq_conv_model conv (.core_clk(core_clk), .sys_rst(sys_rst),
        .convStart(convStart), .convChannel(convChannel),
        .convGain(convGain), .slow(slow), .convDone(convDone),
        .convResult(convResult));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    function automatic logic [31:0] lf(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge core_clk);
            ioWrStb <= 1'b0;
            ioRdStb <= 1'b0;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        ioWrStb <= 1'b1;
        ioRdStb <= 1'b0;
        ioAddr <= a;
        ioWrData <= d;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        ioRdStb <= 1'b1;
        ioWrStb <= 1'b0;
        ioAddr <= a;
        rq.push_back(e);
    endtask
    task automatic scan(input logic [3:0] a, input logic [3:0] b);
        wr(4'h2, {b, a});
        st = a;
        sp = b;
        mux = a;
    endtask
    task automatic note();
        chQ.push_back({gMem[mux], mux});
        mux = (mux == sp) ? st : mux + 4'h1;
    endtask
    task automatic trig(input logic s);
        rnd = lf(rnd);
        wr(4'h0, rnd[7:0]);
        slow <= s;
        note();
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, errTotal);
        if (errTotal == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        if (rdPend) begin
            `CHK("ioRdData", rq[0], ioRdData)
            void'(rq.pop_front());
        end
        rdPend <= (ioRdStb === 1'b1);
        if (convStart === 1'b1) begin
            `CHK("conv", chQ.size() ? chQ[0] : 6'hxx, {convGain, convChannel})
            if (chQ.size() > 0) void'(chQ.pop_front());
        end
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        errTotal++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {ioWrStb, ioRdStb, extTrigIn, pacerTickIn, slow} = '0;
        ioAddr = 4'h0;
        ioWrData = 8'h00;
        digitalInputs = 16'h0000;
        sys_rst = 1'b1;
        rnd = 32'h08b3;
        errTotal = 0;
        compares = 0;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(4'h2, 8'h00);
        idle(2);
        `CHK("digitalOutputs", 16'h0000, digitalOutputs)
        `CHK("analogOutputValue", 12'h000, analogOutputValue)
        for (int i = 0; i < 16; i++) begin
            rnd = lf(rnd);
            gMem[i] = rnd[1:0];
            scan(i[3:0], 4'hf);
            wr(4'h1, rnd[7:0]);
        end
        scan(4'he, 4'h1);
        rd(4'h2, 8'h1e);
        repeat (5) begin
            trig(rnd[1]);
            idle(14);
        end
        rd(4'h0, {2'h1, gMem[14], 4'he});
        rd(4'h1, 8'he9);
        trig(1'b1);
        rd(4'h8, 8'h80);
        idle(14);
        rd(4'h8, 8'h00);
        for (int s = 0; s < 4; s++) begin
            wr(4'h9, s[7:0]);
            if (s < 2) trig(1'b0);
            else begin
                wr(4'h0, 8'hff);
                idle(4);
                extTrigIn <= (s == 2);
                pacerTickIn <= (s == 3);
                note();
                idle(4);
                extTrigIn <= 1'b0;
                pacerTickIn <= 1'b0;
            end
            idle(14);
        end
        rd(4'h9, 8'h03);
        wr(4'h9, 8'h00);
        rnd = lf(rnd);
        digitalInputs <= rnd[15:0];
        idle(4);
        rd(4'h3, rnd[7:0]);
        rd(4'hb, rnd[15:8]);
        wr(4'h3, rnd[23:16]);
        wr(4'hb, rnd[31:24]);
        idle(3);
        `CHK("digitalOutputs", rnd[31:16], digitalOutputs)
        wr(4'h4, 8'h5a);
        idle(2);
        `CHK("analogOutputValue", 12'h000, analogOutputValue)
        wr(4'h5, 8'hc3);
        idle(2);
        `CHK("analogOutputValue", 12'hc35, analogOutputValue)
        wr(4'h4, 8'h0f);
        wr(4'h5, 8'h7e);
        idle(4);
        `CHK("analogOutputValue", 12'h7e0, analogOutputValue)
        report_and_stop();
    end
endmodule
